// ==== inc/apm_pkg.sv ====
// Package of shared constants and types for the audio/card pin multiplexer.
`default_nettype none
package apm_pkg;

   // Number of general-purpose-shared output pins handled by the mux.
   localparam int NPIN = 18;

   // Index of each shared pin inside the pin vectors.
   localparam int PIN_CONSUMER_AUDIO_OUT = 0;
   localparam int PIN_PRO_AUDIO_OUT      = 1;
   localparam int PIN_TIMER_REF          = 2;
   localparam int PIN_SUBCODE_SYNC_OUT   = 3;
   localparam int PIN_SUBCODE_DATA_OUT   = 4;
   localparam int PIN_QS_DATA_OUT        = 5;
   localparam int PIN_QS_SELECT_0        = 6;
   localparam int PIN_XTAL_TRIM_OUT      = 10;
   localparam int PIN_DAC_CLOCK_OUT_1    = 11;
   localparam int PIN_DAC_CLOCK_OUT_2    = 12;
   localparam int PIN_CARD_CLOCK_OUT     = 13;
   localparam int PIN_CARD_CMD           = 14;
   localparam int PIN_CARD_DATA0         = 15;
   localparam int PIN_CARD_DATA1         = 16;
   localparam int PIN_CARD_DATA3         = 17;

   // Function select during reset: only the two audio outputs are peripheral.
   localparam logic [NPIN-1:0] FUNC_RESET = 18'h00003;

   // Field positions of the clock control bits.
   localparam int CCR_RESET_PIN_SEL = 0;
   localparam int CCR_SERIAL_SEL    = 1;

   // Test-mode codes that pick the debug or the boundary-scan pin functions.
   localparam logic [3:0] TM_DEBUG = 4'h1;
   localparam logic [3:0] TM_SCAN  = 4'h0;

   // Widths of the density modulators and of one subcode word.
   localparam int PDM_W = 8;
   localparam int SUB_W = 8;

   // Subcode serialiser states, Gray coded.
   typedef enum logic [1:0] {
      APM_SC_IDLE  = 2'h0,
      APM_SC_SHIFT = 2'h1
   } apm_sc_state_t;

endpackage : apm_pkg
`default_nettype wire

// ==== inc/apm_pdm_if.sv ====
// Interface carrying a level into a pulse-density modulator and its bit back.
`default_nettype none
interface apm_pdm_if #(parameter int W = 8) ();
   logic [W-1:0] level;
   logic         bit_out;
   modport gen (input level, output bit_out);
   modport src (output level, input bit_out);
endinterface : apm_pdm_if
`default_nettype wire

// ==== rtl/apm_pdm.sv ====
// First-order pulse-density modulator.
`default_nettype none
module apm_pdm
   import apm_pkg::*;
#(
   parameter int W = PDM_W
) (
   input  wire logic clock,
   input  wire logic reset,
   apm_pdm_if.gen    pdm
);

   logic [W-1:0] acc;
   logic [W:0]   sum;

   // The carry of the running sum is the output density.
   assign sum = {1'b0, acc} + {1'b0, pdm.level};

   // Accumulator and registered output bit.
   always_ff @(posedge clock) begin
      if (reset) begin
         acc         <= '0;
         pdm.bit_out <= 1'b0;
      end else begin
         acc         <= sum[W-1:0];
         pdm.bit_out <= sum[W];
      end
   end

endmodule : apm_pdm
`default_nettype wire

// ==== rtl/apm_subcode.sv ====
// Subcode word serialiser clocked by the encoder's subcode clock ticks.
`default_nettype none
module apm_subcode
   import apm_pkg::*;
#(
   parameter int W = SUB_W
) (
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         enable,
   input  wire logic         tick,
   input  wire logic [W-1:0] word,
   input  wire logic         sync_req,
   output logic              take,
   output logic              sync_out,
   output logic              data_out
);

   localparam int CW = $clog2(W);

   apm_sc_state_t state;
   logic [W-1:0]  shreg;
   logic [CW-1:0] cnt;
   logic          last;

   // A new word is taken on the tick after the previous word's last bit.
   assign take = enable && tick && (state == APM_SC_IDLE);
   assign last = (cnt == CW'(1));

   always_ff @(posedge clock) begin
      if (reset || !enable) begin
         state    <= APM_SC_IDLE;
         shreg    <= '0;
         cnt      <= '0;
         sync_out <= 1'b0;
         data_out <= 1'b0;
      end else if (take) begin
         state    <= APM_SC_SHIFT;
         shreg    <= word;
         cnt      <= CW'(W - 1);
         sync_out <= sync_req;
         data_out <= word[W-1];
      end else if (tick) begin
         shreg    <= {shreg[W-2:0], 1'b0};
         cnt      <= cnt - 1'b1;
         sync_out <= 1'b0;
         data_out <= shreg[W-2];
         if (last) begin
            state <= APM_SC_IDLE;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_sync_on_load: assert property (
      take |=> sync_out == $past(sync_req))
      else $error("subcode sync does not follow the request");
   chk_sync_one_bit: assert property (
      sync_out && tick |=> !sync_out)
      else $error("subcode sync held past one bit");
   chk_word_msb: assert property (
      take |=> data_out == $past(word[W-1]) && state == APM_SC_SHIFT)
      else $error("subcode first bit wrong");

endmodule : apm_subcode
`default_nettype wire

// ==== rtl/apm_pin_mux.sv ====
// Pin-function multiplexer for audio, subcode, converter, card and serial pins.
//
// How it works
// - Audio input pins feed general input and receiver paths together.
// - All four audio input levels always readable as general inputs.
// - A select input routes one audio input pin to the receiver.
// - Function select picks gpio or audio out; reset forces audio out.
// - First output carries consumer audio, second carries professional audio.
// - Subcode leaves serially on sync and data lines, clocked by encoder.
// - Sync output goes high when a subcode sync is inserted.
// - Converter reference leaves as density stream; four comparator inputs read.
// - Timer/reference pin: gpio or peripheral; config bit picks timer or reference.
// - Card pins serve one four-bit card or two strobe cards.
// - One card clock pin serves all card ports.
// - Shared reset pin is reset output or card data2/strobe2 by select.
// - Shared serial pins are two-wire or queued-serial by select.
// - Four queued-serial chip selects, each shared with general pins.
// - Crystal trim leaves as density stream of phase difference.
// - Converter clock pins carry the crystal clock directly.
// - Test code 0001 selects debug, 0000 boundary-scan pin functions.
`default_nettype none
module apm_pin_mux
   import apm_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            reset,
   input  wire logic            audio_in_pin_1,
   input  wire logic            audio_in_pin_2,
   input  wire logic            audio_in_pin_3,
   input  wire logic            audio_in_pin_4,
   input  wire logic            rxd2_pin,
   input  wire logic            cts2_pin,
   input  wire logic            subcode_clk_in,
   input  wire logic [3:0]      test_mode_pin,
   input  wire logic            xtal_clk,
   input  wire logic [NPIN-1:0] gp_pin_i,
   output logic [NPIN-1:0]      gp_pin_o,
   output logic [NPIN-1:0]      gp_pin_oe,
   input  wire logic            card_data2_strobe2_i,
   output logic                 card_data2_strobe2_o,
   output logic                 card_data2_strobe2_oe,
   input  wire logic            shared_serial_clock_i,
   output logic                 shared_serial_clock_o,
   output logic                 shared_serial_clock_oe,
   input  wire logic            shared_serial_data_in_i,
   output logic                 shared_serial_data_in_o,
   output logic                 shared_serial_data_in_oe,
   input  wire logic [NPIN-1:0] pin_function_select_hi,
   input  wire logic [NPIN-1:0] gpio_out_data,
   input  wire logic [NPIN-1:0] gpio_dir,
   output logic [NPIN-1:0]      gpio_in_data,
   output logic [3:0]           audio_gpi,
   input  wire logic [1:0]      audio_rx_sel,
   output logic                 iec_rx_in,
   input  wire logic            consumer_audio_data,
   input  wire logic            pro_audio_data,
   input  wire logic [SUB_W-1:0] subcode_word,
   input  wire logic            subcode_sync_req,
   output logic                 subcode_word_take,
   output logic [3:0]           comparator_result,
   input  wire logic [PDM_W-1:0] conv_ref_level,
   input  wire logic            converter_config_reg,
   input  wire logic            timer1_out,
   input  wire logic            card_mode_strobe,
   input  wire logic            card_clock,
   input  wire logic [3:0]      card_do,
   input  wire logic [3:0]      card_doe,
   input  wire logic            card_cmd_o,
   input  wire logic            card_cmd_oe,
   input  wire logic            card_strobe1,
   input  wire logic            card_strobe2,
   output logic [3:0]           card_di,
   output logic                 card_cmd_i,
   input  wire logic            reset_out,
   input  wire logic [1:0]      clock_control_reg,
   input  wire logic            i2c_scl_low,
   input  wire logic            i2c_sda_low,
   output logic                 i2c_scl_in,
   output logic                 i2c_sda_in,
   input  wire logic            qspi_clk,
   output logic                 qspi_din,
   input  wire logic            qspi_dout,
   input  wire logic [3:0]      qspi_cs,
   input  wire logic [PDM_W-1:0] xtal_phase_level,
   output logic                 debug_func_sel,
   output logic                 scan_func_sel
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   localparam int NS = 14;

   logic [NS-1:0]   raw_in;
   logic [NS-1:0]   s1;
   logic [NS-1:0]   s2;
   logic [NPIN-1:0] gp_s1;
   logic            rck_s3;
   logic            rck_tick;
   wire  [3:0]      aud_s2  = s2[3:0];
   wire  [3:0]      tm_s2   = s2[13:10];
   wire             rck_s2  = s2[6];

   assign raw_in = {test_mode_pin, card_data2_strobe2_i, shared_serial_data_in_i,
                    shared_serial_clock_i, subcode_clk_in, cts2_pin, rxd2_pin,
                    audio_in_pin_4, audio_in_pin_3, audio_in_pin_2, audio_in_pin_1};

   // Two flops on every pin input but the crystal clock; the subcode clock gets a third flop for its edge detect.
   always_ff @(posedge clock) begin
      s1           <= raw_in;
      s2           <= s1;
      gp_s1        <= gp_pin_i;
      gpio_in_data <= gp_s1;
      rck_s3       <= rck_s2;
   end

   // Rising edge of the synchronised subcode clock.
   assign rck_tick = rck_s2 && !rck_s3;

   ////////////////////////////////////////////////////////////////////////////
   // Audio inputs, comparators and receiver routing.

   always_ff @(posedge clock) begin
      audio_gpi         <= aud_s2;
      comparator_result <= {s2[5], s2[4], aud_s2[3], aud_s2[2]};
      iec_rx_in         <= aud_s2[audio_rx_sel];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control capture.

   logic [NPIN-1:0] func_sel;
   logic            card_mode_q;
   logic [1:0]      ccr_q;

   assign func_sel = reset ? FUNC_RESET : pin_function_select_hi;

   // Card mode and clock control switch all their pins in the same cycle.
   always_ff @(posedge clock) begin
      if (reset) begin
         card_mode_q <= 1'b0;
         ccr_q       <= 2'h0;
      end else begin
         card_mode_q <= card_mode_strobe;
         ccr_q       <= clock_control_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Density modulators and subcode serialiser.

   apm_pdm_if #(.W(PDM_W)) ref_if ();
   apm_pdm_if #(.W(PDM_W)) trim_if ();
   logic sub_sync;
   logic sub_data;

   assign ref_if.level  = conv_ref_level;
   assign trim_if.level = xtal_phase_level;

   apm_pdm #(.W(PDM_W)) u_ref_pdm (
      .clock (clock),
      .reset (reset),
      .pdm   (ref_if.gen)
   );

   apm_pdm #(.W(PDM_W)) u_trim_pdm (
      .clock (clock),
      .reset (reset),
      .pdm   (trim_if.gen)
   );

   apm_subcode #(.W(SUB_W)) u_subcode (
      .clock    (clock),
      .reset    (reset),
      .enable   (func_sel[PIN_SUBCODE_SYNC_OUT]),
      .tick     (rck_tick),
      .word     (subcode_word),
      .sync_req (subcode_sync_req),
      .take     (subcode_word_take),
      .sync_out (sub_sync),
      .data_out (sub_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral side of each shared pin.

   wire d1_o  = card_mode_q ? card_strobe1 : card_do[1];
   wire d1_oe = card_mode_q ? 1'b1 : card_doe[1];
   wire d3_oe = card_mode_q ? 1'b0 : card_doe[3];
   wire tref  = converter_config_reg ? ref_if.bit_out : timer1_out;

   logic [NPIN-1:0] periph_o;
   logic [NPIN-1:0] periph_oe;

   assign periph_o  = {card_do[3], d1_o, card_do[0], card_cmd_o, card_clock,
                       xtal_clk, xtal_clk, trim_if.bit_out, qspi_cs, qspi_dout,
                       sub_data, sub_sync, tref, pro_audio_data, consumer_audio_data};
   assign periph_oe = {d3_oe, d1_oe, card_doe[0], card_cmd_oe, 14'h3FFF};

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin function select.

   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      if (i == PIN_DAC_CLOCK_OUT_1 || i == PIN_DAC_CLOCK_OUT_2) begin : g_clk
         // Crystal clock passes unretimed; a flop here would resample its edges onto the system clock.
         assign gp_pin_o[i]  = func_sel[i] ? xtal_clk : gpio_out_data[i];
         assign gp_pin_oe[i] = func_sel[i] | gpio_dir[i];
      end else begin : g_reg
         always_ff @(posedge clock) begin
            gp_pin_o[i]  <= func_sel[i] ? periph_o[i] : gpio_out_data[i];
            gp_pin_oe[i] <= func_sel[i] ? periph_oe[i] : gpio_dir[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared reset and serial pins, card and serial inputs.

   always_ff @(posedge clock) begin
      if (!ccr_q[CCR_RESET_PIN_SEL]) begin
         card_data2_strobe2_o  <= reset_out;
         card_data2_strobe2_oe <= 1'b1;
      end else begin
         card_data2_strobe2_o  <= card_mode_q ? card_strobe2 : card_do[2];
         card_data2_strobe2_oe <= card_mode_q | card_doe[2];
      end
      if (ccr_q[CCR_SERIAL_SEL]) begin
         shared_serial_clock_o    <= qspi_clk;
         shared_serial_clock_oe   <= 1'b1;
         shared_serial_data_in_oe <= 1'b0;
      end else begin
         shared_serial_clock_o    <= 1'b0;
         shared_serial_clock_oe   <= i2c_scl_low;
         shared_serial_data_in_oe <= i2c_sda_low;
      end
      shared_serial_data_in_o <= 1'b0;
   end

   // Synchronised returns towards the card, two-wire and serial blocks.
   always_ff @(posedge clock) begin
      card_di    <= {gpio_in_data[PIN_CARD_DATA3], s2[9],
                     gpio_in_data[PIN_CARD_DATA1], gpio_in_data[PIN_CARD_DATA0]};
      card_cmd_i <= gpio_in_data[PIN_CARD_CMD];
      i2c_scl_in <= s2[7];
      i2c_sda_in <= s2[8];
      qspi_din   <= s2[8];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test-mode decode.

   always_ff @(posedge clock) begin
      if (reset) begin
         debug_func_sel <= 1'b0;
         scan_func_sel  <= 1'b0;
      end else begin
         debug_func_sel <= (tm_s2 == TM_DEBUG);
         scan_func_sel  <= (tm_s2 == TM_SCAN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_gpi_tracks_pin: assert property (
      ##3 audio_gpi[0] == $past(audio_in_pin_1, 3))
      else $error("gpi does not follow audio pin 1");
   chk_rx_route: assert property (
      ##1 iec_rx_in == $past(aud_s2[audio_rx_sel]))
      else $error("receiver input not routed from selected pin");
   chk_aout_reset: assert property (@(posedge clock) disable iff (1'b0)
      reset |=> gp_pin_o[PIN_CONSUMER_AUDIO_OUT] == $past(consumer_audio_data))
      else $error("consumer output not audio during reset");
   chk_gpio_pin: assert property (
      !func_sel[PIN_QS_DATA_OUT] |=> gp_pin_o[PIN_QS_DATA_OUT] ==
      $past(gpio_out_data[PIN_QS_DATA_OUT]) && gp_pin_oe[PIN_QS_DATA_OUT] ==
      $past(gpio_dir[PIN_QS_DATA_OUT]))
      else $error("gpio pin not following data register");
   chk_ref_select: assert property (
      func_sel[PIN_TIMER_REF] && converter_config_reg |=>
      gp_pin_o[PIN_TIMER_REF] == $past(ref_if.bit_out))
      else $error("reference stream not on timer pin");
   chk_reset_pin: assert property (
      !ccr_q[CCR_RESET_PIN_SEL] |=> card_data2_strobe2_oe &&
      card_data2_strobe2_o == $past(reset_out))
      else $error("shared pin not carrying reset output");
   chk_serial_qspi: assert property (
      ccr_q[CCR_SERIAL_SEL] |=> shared_serial_clock_o == $past(qspi_clk) &&
      !shared_serial_data_in_oe)
      else $error("serial pins not in queued mode");
   chk_debug_sel: assert property (
      tm_s2 == TM_DEBUG |=> debug_func_sel && !scan_func_sel)
      else $error("debug functions not selected");
   chk_strobe_mode: assert property (
      card_mode_q && func_sel[PIN_CARD_DATA3] |=> !gp_pin_oe[PIN_CARD_DATA3])
      else $error("data3 driven in strobe card mode");

   cov_strobe_cards: cover property (card_mode_q ##1 card_strobe1);
   cov_qspi_mode: cover property (ccr_q[CCR_SERIAL_SEL] ##1 qspi_clk);
   cov_subcode_sync: cover property (subcode_word_take && subcode_sync_req);
   cov_debug_mode: cover property (debug_func_sel);

endmodule : apm_pin_mux
`default_nettype wire

// ==== sim/apm_far_side.sv ====
// Model of the encoder, crystal and board that sit around the pin multiplexer.
`default_nettype none
module apm_far_side (
   input  wire logic       clock,
   input  wire logic       tick_on,
   input  wire logic [3:0] test_cmd,
   output logic            subcode_clk_in,
   output logic [3:0]      test_mode_pin,
   output logic            xtal_clk
);
   timeunit 1ns;
   timeprecision 100ps;

   // The crystal runs free at 20 MHz, its edges never meet the bench's sample points.
   initial begin
      xtal_clk = 1'b0;
      forever #25 xtal_clk = ~xtal_clk;
   end

   // encoder drives clock
   // The subcode clock toggles every four system clocks while enabled and rests low.
   initial begin
      subcode_clk_in = 1'b0;
      forever begin
         repeat (4) @(posedge clock);
         #2 subcode_clk_in = tick_on & ~subcode_clk_in;
      end
   end

   // board holds test
   // The test inputs stay low unless the bench asks for debug mode.
   assign test_mode_pin = test_cmd;
endmodule : apm_far_side
`default_nettype wire

// ==== sim/apm_pin_mux_test.sv ====
// Self-checking bench for the pin multiplexer with a far-side board model.
`default_nettype none
module apm_pin_mux_test
   import apm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 clock, reset, tick_on, cfg, cmode;
   logic [31:0]          r;
   logic [NPIN-1:0]      gpi, fsel, dout, dir, pv;
   logic [1:0]           sel2, ccr;
   logic [3:0]           tcmd;
   logic [7:0]           word, lvl, plvl, m8;
   logic [8:0]           ones_r, ones_x;
   logic [NPIN-1:0]      exp_q[$], msk_q[$];
   int                   sel_q[$];
   int                   n_errors, num_checks, k;
   event                 chk;
   wire logic [NPIN-1:0] gp_pin_o, gp_pin_oe, gpio_in_data;
   wire logic [3:0]      audio_gpi, comparator_result, test_mode_pin, card_di;
   wire logic            subcode_clk_in, xtal_clk, iec_rx_in, subcode_word_take, dbg, scn;
   wire logic            cd2_o, cd2_oe, ssc_o, ssc_oe, ssd_o, ssd_oe;
   wire logic            cmd_i, scl_in, sda_in, qdin;

   apm_far_side apm_far_side_inst (.clock, .tick_on, .test_cmd(tcmd), .subcode_clk_in,
      .test_mode_pin, .xtal_clk);

   // Pin levels are resolved from the enables; released general pins read gpi, other released lines are pulled up.
   apm_pin_mux apm_pin_mux_inst (.clock, .reset, .audio_in_pin_1(r[28]),
      .audio_in_pin_2(r[29]), .audio_in_pin_3(r[30]), .audio_in_pin_4(r[31]),
      .rxd2_pin(r[0]), .cts2_pin(r[1]), .subcode_clk_in, .test_mode_pin, .xtal_clk,
      .gp_pin_i((gp_pin_oe & gp_pin_o) | (~gp_pin_oe & gpi)), .gp_pin_o, .gp_pin_oe,
      .card_data2_strobe2_i(cd2_oe ? cd2_o : 1'b1), .card_data2_strobe2_o(cd2_o),
      .card_data2_strobe2_oe(cd2_oe), .shared_serial_clock_i(ssc_oe ? ssc_o : 1'b1),
      .shared_serial_clock_o(ssc_o), .shared_serial_clock_oe(ssc_oe),
      .shared_serial_data_in_i(ssd_oe ? ssd_o : 1'b1), .shared_serial_data_in_o(ssd_o),
      .shared_serial_data_in_oe(ssd_oe), .pin_function_select_hi(fsel),
      .gpio_out_data(dout), .gpio_dir(dir), .gpio_in_data, .audio_gpi,
      .audio_rx_sel(sel2), .iec_rx_in, .consumer_audio_data(r[2]), .pro_audio_data(r[3]),
      .subcode_word(word), .subcode_sync_req(r[15]), .subcode_word_take,
      .comparator_result, .conv_ref_level(lvl), .converter_config_reg(cfg),
      .timer1_out(r[4]), .card_mode_strobe(cmode), .card_clock(r[5]),
      .card_do(r[19:16]), .card_doe(r[23:20]), .card_cmd_o(r[6]), .card_cmd_oe(r[7]),
      .card_strobe1(r[8]), .card_strobe2(r[9]), .card_di, .card_cmd_i(cmd_i),
      .reset_out(r[10]), .clock_control_reg(ccr), .i2c_scl_low(r[11]),
      .i2c_sda_low(r[12]), .i2c_scl_in(scl_in), .i2c_sda_in(sda_in), .qspi_clk(r[13]),
      .qspi_din(qdin), .qspi_dout(r[14]), .qspi_cs(r[27:24]), .xtal_phase_level(plvl),
      .debug_func_sel(dbg), .scan_func_sel(scn));

   ////////////////////////////////////////////////////////////////////////////////
   // Each drive step lands the same small delay after the rising edge.
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step

   // A note records which output to look at, which bits matter and the expected value.
   task automatic note(int s, logic [NPIN-1:0] m, logic [NPIN-1:0] e);
      sel_q.push_back(s);
      msk_q.push_back(m);
      exp_q.push_back(e);
      ->chk;
   endtask : note

   function automatic logic [NPIN-1:0] seen(int s);
      case (s)
         0: return gp_pin_o;
         1: return gp_pin_oe;
         2: return gpio_in_data;
         3: return 18'(audio_gpi);
         4: return 18'(comparator_result);
         5: return 18'(ones_r);
         6: return 18'(ones_x);
         7: return 18'(iec_rx_in);
         8: return 18'(ssc_o);
         9: return 18'(ssc_oe);
         10: return 18'(cd2_o);
         11: return 18'(dbg);
         13: return 18'({cmd_i, card_di, scl_in, sda_in, qdin});
         default: return 18'(scn);
      endcase
   endfunction : seen

   task automatic compare_vec(logic [NPIN-1:0] a, logic [NPIN-1:0] e);
      num_checks++;
      if (a !== e) begin
         n_errors++;
         $display("unexpected vector at %0t: got %h, want %h", $time, a, e);
      end
   endtask : compare_vec

   task automatic compare_bit(logic a, logic e);
      num_checks++;
      if (a !== e) begin
         n_errors++;
         $display("unexpected bit at %0t: got %h, want %h", $time, a, e);
      end
   endtask : compare_bit

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////////
   // The watcher takes the oldest notes and compares them with what the outputs show.
   initial begin
      int              s;
      logic [NPIN-1:0] v;
      logic [NPIN-1:0] e;
      forever begin
         @chk;
         while (sel_q.size() > 0) begin
            s = sel_q.pop_front();
            v = seen(s) & msk_q.pop_front();
            e = exp_q.pop_front();
            if (s < 7 || s == 13) compare_vec(v, e);
            else compare_bit(v[0], e[0]);
         end
      end
   end

   // The system clock runs at 50 MHz.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // A hang is cut short well past the expected run length.
   initial begin
      #100us;
      n_errors++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The tests run one after another from reset.
   initial begin
      {tick_on, cfg, cmode, gpi, fsel, dout, dir, sel2, ccr, tcmd, word, lvl, plvl} = '0;
      {ones_r, ones_x} = '0;
      reset = 1'b1;
      void'($urandom(32'h649E37CF));
      r = $urandom;
      step(11);
      note(0, 18'h3, 18'({r[3], r[2]}));
      note(1, 18'h3, 18'h3);
      step(1);
      reset = 1'b0;
      $display("reset test done");
      repeat (8) begin
         r = $urandom;
         {fsel, dout, dir, gpi} = {18'($urandom), 18'($urandom), 18'($urandom), 18'($urandom)};
         step(1);
         note(0, ~fsel & dir, dout & ~fsel & dir);
         note(1, ~fsel, dir & ~fsel);
         step(2);
         pv = (dir & dout) | (~dir & gpi);
         note(2, ~fsel, pv & ~fsel);
         step(1);
         m8 = {~fsel[14], ~fsel[17], 1'b1, ~fsel[16:15], 3'h7};
         note(13, 18'(m8), 18'(m8 & {pv[14], pv[17], r[10], pv[16:15], ~r[11], ~r[12],
            ~r[12]}));
      end
      $display("gpio test done");
      for (k = 0; k < 4; k++) begin
         r = $urandom;
         sel2 = 2'(k);
         step(3);
         note(3, 18'hF, 18'(r[31:28]));
         note(7, 18'h1, 18'(r[28 + k]));
         note(4, 18'hF, 18'({r[1:0], r[31:30]}));
         step(1);
      end
      $display("audio input test done");
      fsel = '1;
      for (k = 0; k < 4; k++) begin
         r = $urandom;
         ccr = 2'(k);
         cfg = ccr[1];
         cmode = ^ccr;
         step(2);
         note(0, 18'h13847, {1'b0, cmode ? r[8] : r[17], 2'b0, r[5], xtal_clk, xtal_clk, 4'b0,
            r[24], 3'b0, cfg ? 1'b0 : r[4], r[3], r[2]});
         note(8, 18'h1, 18'(ccr[1] & r[13]));
         note(9, 18'h1, 18'(ccr[1] | r[11]));
         note(10, 18'h1, 18'(ccr[0] ? (cmode ? r[9] : r[18]) : r[10]));
         step(1);
      end
      $display("peripheral pin test done");
      {cfg, lvl, plvl} = {1'b1, 8'h40, 8'hC0};
      step(4);
      repeat (256) begin
         @(posedge clock);
         #1 ones_r += 9'(gp_pin_o[PIN_TIMER_REF]);
         ones_x += 9'(gp_pin_o[PIN_XTAL_TRIM_OUT]);
      end
      #1;
      note(5, 18'h1FF, 18'd64);
      note(6, 18'h1FF, 18'd192);
      step(1);
      tcmd = 4'h1;
      step(4);
      note(11, 18'h1, 18'h1);
      note(12, 18'h1, 18'h0);
      step(1);
      tcmd = 4'h0;
      step(4);
      note(11, 18'h1, 18'h0);
      note(12, 18'h1, 18'h1);
      step(1);
      $display("density and test mode done");
      fsel = '0;
      step(1);
      {fsel, word, r, tick_on} = {18'h18, 8'($urandom), $urandom, 1'b1};
      for (k = 0; k < 100 && subcode_word_take !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      if (k == 100) n_errors++;
      step(2);
      note(0, 18'h18, 18'({word[7], r[15]}) << 3);
      step(8);
      note(0, 18'h18, 18'(word[6]) << 4);
      step(1);
      tick_on = 1'b0;
      $display("subcode test done");
      stop_test();
   end
endmodule : apm_pin_mux_test
`default_nettype wire
